// ---- src/dpram_host.sv ----
// Host controller driving one port of an asynchronous dual-port memory with semaphores.
// Assumes port inputs are synchronous to MCLK and software on an AHB-Lite bus.
//
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.

`timescale 1ns/1ps
`default_nettype none

module dpram_host (
	input  wire logic        MCLK,
	input  wire logic        NRST,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output var  logic        HREADYOUT,
	output var  logic        HRESP,
	output var  logic [31:0] HRDATA,
	output var  logic        IRQ,
	output var  logic [14:0] PORT_ADDR,
	input  wire logic [7:0]  PORT_DATA_I,
	output var  logic [7:0]  PORT_DATA_O,
	output var  logic [7:0]  PORT_DATA_OE,
	output var  logic        PORT_SELECT_N,
	output var  logic        FLAG_SPACE_SELECT_N,
	output var  logic        PORT_WRITE_N,
	output var  logic        PORT_OUT_DRIVE_N,
	input  wire logic        PORT_CONTENTION_N,
	input  wire logic        PORT_INT_N,
	output var  logic        CASCADE_ROLE
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	dpram_host_pkg::state_t                state;
	logic [3:0]                            cnt;
	logic [dpram_host_pkg::OP_W-1:0]       op;
	logic                                  take_read;
	logic [dpram_host_pkg::ADDR_W-1:0]     addr_reg;
	logic [dpram_host_pkg::DATA_W-1:0]     wdata_reg;
	logic [dpram_host_pkg::DATA_W-1:0]     rdata_reg;
	logic                                  grant;
	logic                                  role;
	logic [dpram_host_pkg::IRQ_W-1:0]      irq_mask;
	logic [dpram_host_pkg::IRQ_W-1:0]      irq_flags;
	logic [dpram_host_pkg::IRQ_W-1:0]      irq_set;
	logic                                  irq_clr;
	logic                                  wr_pend;
	logic [dpram_host_pkg::REG_OFS_W-1:0]  wr_ofs;
	logic                                  rd_take;
	logic                                  addr_ok;
	logic                                  cmd_start;
	logic                                  is_flag;
	logic                                  is_write;
	logic                                  leave_strobe;
	logic                                  more_phase;
	logic                                  int_prev;
	logic [dpram_host_pkg::DATA_W-1:0]     out_byte;
	logic [31:0]                           next_hrdata;
	logic [dpram_host_pkg::REG_OFS_W-1:0]  ofs;

	// ------------------------------------------------------------
	// Bus slave: zero wait states, always OKAY
	// ------------------------------------------------------------
	assign HREADYOUT = 1'b1;
	assign HRESP     = dpram_host_pkg::HRESP_OKAY;
	assign ofs       = HADDR[dpram_host_pkg::REG_OFS_W-1:0];
	assign addr_ok   = (HADDR[31:dpram_host_pkg::REG_OFS_W] == '0);
	assign rd_take   = HSEL && HREADY && (HTRANS == dpram_host_pkg::HTRANS_NSEQ) && !HWRITE;

	// Capture write address phase; data follows next cycle
	always_ff @(posedge MCLK or negedge NRST)
	begin
		if (!NRST)
		begin
			wr_pend <= 1'b0;
			wr_ofs  <= dpram_host_pkg::WORD_ZERO_HI;
		end
		else
		begin
			wr_pend <= HSEL && HREADY && (HTRANS == dpram_host_pkg::HTRANS_NSEQ)
				&& HWRITE && addr_ok;
			wr_ofs  <= ofs;
		end
	end

	// Read mux; unmapped offsets read as zero
	always_comb
	begin
		next_hrdata = '0;
		if (addr_ok)
		begin
			case (ofs)
				dpram_host_pkg::REG_CMD:      next_hrdata[dpram_host_pkg::OP_W-1:0] = op;
				dpram_host_pkg::REG_ADDR:     next_hrdata[dpram_host_pkg::ADDR_W-1:0] = addr_reg;
				dpram_host_pkg::REG_WDATA:    next_hrdata[dpram_host_pkg::DATA_W-1:0] = wdata_reg;
				dpram_host_pkg::REG_RDATA:    next_hrdata[dpram_host_pkg::DATA_W-1:0] = rdata_reg;
				dpram_host_pkg::REG_STATUS:
				begin
					next_hrdata[dpram_host_pkg::ST_BUSY_BIT]  = (state != dpram_host_pkg::S_IDLE);
					next_hrdata[dpram_host_pkg::ST_GRANT_BIT] = grant;
					next_hrdata[dpram_host_pkg::ST_CONT_BIT]  = !PORT_CONTENTION_N;
					next_hrdata[dpram_host_pkg::ST_INT_BIT]   = !PORT_INT_N;
				end
				dpram_host_pkg::REG_CFG:      next_hrdata[dpram_host_pkg::CFG_ROLE_BIT] = role;
				dpram_host_pkg::REG_IRQ_STAT: next_hrdata[dpram_host_pkg::IRQ_W-1:0] = irq_flags;
				dpram_host_pkg::REG_IRQ_MASK: next_hrdata[dpram_host_pkg::IRQ_W-1:0] = irq_mask;
				default:                      next_hrdata = '0;
			endcase
		end
	end

	// Read data registered at the address-phase edge
	always_ff @(posedge MCLK or negedge NRST)
	begin
		if (!NRST)
			HRDATA <= '0;
		else if (rd_take)
			HRDATA <= next_hrdata;
	end

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	// A command while busy is dropped; software polls the busy bit
	assign cmd_start = wr_pend && (wr_ofs == dpram_host_pkg::REG_CMD)
		&& (state == dpram_host_pkg::S_IDLE);

	always_ff @(posedge MCLK or negedge NRST)
	begin
		if (!NRST)
		begin
			addr_reg  <= '0;
			wdata_reg <= '0;
			role      <= dpram_host_pkg::ROLE_RESET;
			irq_mask  <= '0;
		end
		else if (wr_pend)
		begin
			case (wr_ofs)
				dpram_host_pkg::REG_ADDR:     addr_reg  <= HWDATA[dpram_host_pkg::ADDR_W-1:0];
				dpram_host_pkg::REG_WDATA:    wdata_reg <= HWDATA[dpram_host_pkg::DATA_W-1:0];
				dpram_host_pkg::REG_CFG:      role      <= HWDATA[dpram_host_pkg::CFG_ROLE_BIT];
				dpram_host_pkg::REG_IRQ_MASK: irq_mask  <= HWDATA[dpram_host_pkg::IRQ_W-1:0];
				default:                      role      <= role;
			endcase
		end
	end

	// Role pin picks master or slave cascade behaviour of the device
	assign CASCADE_ROLE = role;

	// ------------------------------------------------------------
	// Access sequencer
	// ------------------------------------------------------------
	assign is_flag  = (op == dpram_host_pkg::OP_FLAG_RD) || (op == dpram_host_pkg::OP_FLAG_WR)
		|| (op == dpram_host_pkg::OP_FLAG_TAKE);
	assign is_write = (op == dpram_host_pkg::OP_MEM_WR) || (op == dpram_host_pkg::OP_FLAG_WR)
		|| ((op == dpram_host_pkg::OP_FLAG_TAKE) && !take_read);
	// Strobe ends only once the contention flag is released
	assign leave_strobe = (state == dpram_host_pkg::S_STROBE) && PORT_CONTENTION_N
		&& (cnt <= dpram_host_pkg::CNT_LAST);
	assign more_phase   = (op == dpram_host_pkg::OP_FLAG_TAKE) && !take_read;

	always_ff @(posedge MCLK or negedge NRST)
	begin
		if (!NRST)
		begin
			state     <= dpram_host_pkg::S_IDLE;
			cnt       <= '0;
			op        <= dpram_host_pkg::OP_MEM_RD;
			take_read <= 1'b0;
		end
		else
		begin
			case (state)
				dpram_host_pkg::S_IDLE:
					if (cmd_start)
					begin
						op        <= HWDATA[dpram_host_pkg::OP_W-1:0];
						take_read <= 1'b0;
						state     <= dpram_host_pkg::S_SETUP;
					end
				dpram_host_pkg::S_SETUP:
				begin
					cnt   <= dpram_host_pkg::ACCESS_CYC;
					state <= dpram_host_pkg::S_STROBE;
				end
				dpram_host_pkg::S_STROBE:
					if (leave_strobe)
						state <= dpram_host_pkg::S_RELEASE;
					else if (PORT_CONTENTION_N && (cnt > dpram_host_pkg::CNT_LAST))
						cnt <= cnt - dpram_host_pkg::CNT_LAST;
				dpram_host_pkg::S_RELEASE:
					if (more_phase)
					begin
						take_read <= 1'b1;
						state     <= dpram_host_pkg::S_SETUP;
					end
					else
						state <= dpram_host_pkg::S_IDLE;
				default:
					state <= dpram_host_pkg::S_IDLE;
			endcase
		end
	end

	// Byte put on the data lines; flag writes carry only bit zero
	always_comb
	begin
		out_byte = wdata_reg;
		if (op == dpram_host_pkg::OP_FLAG_TAKE)
		begin
			out_byte = '0;
			out_byte[dpram_host_pkg::FLAG_BIT] = dpram_host_pkg::FLAG_REQUEST;
		end
		else if (is_flag)
		begin
			out_byte = '0;
			out_byte[dpram_host_pkg::FLAG_BIT] = wdata_reg[dpram_host_pkg::FLAG_BIT];
		end
	end

	// ------------------------------------------------------------
	// Port pins, all registered
	// ------------------------------------------------------------
	// Address and data load at the same edge at which the select and strobe fall
	always_ff @(posedge MCLK or negedge NRST)
	begin
		if (!NRST)
		begin
			PORT_ADDR    <= '0;
			PORT_DATA_O  <= '0;
			PORT_DATA_OE <= '0;
		end
		else if (state == dpram_host_pkg::S_SETUP)
		begin
			PORT_ADDR    <= addr_reg;
			PORT_DATA_O  <= out_byte;
			PORT_DATA_OE <= {dpram_host_pkg::DATA_W{is_write}};
		end
		else if ((state == dpram_host_pkg::S_RELEASE) || (state == dpram_host_pkg::S_IDLE))
			PORT_DATA_OE <= '0;
	end

	// Selects and strobes; exactly one select falls per access
	always_ff @(posedge MCLK or negedge NRST)
	begin
		if (!NRST)
		begin
			PORT_SELECT_N       <= 1'b1;
			FLAG_SPACE_SELECT_N <= 1'b1;
			PORT_WRITE_N        <= 1'b1;
			PORT_OUT_DRIVE_N    <= 1'b1;
		end
		else if (state == dpram_host_pkg::S_SETUP)
		begin
			PORT_SELECT_N       <= is_flag;
			FLAG_SPACE_SELECT_N <= !is_flag;
			PORT_WRITE_N        <= !is_write;
			PORT_OUT_DRIVE_N    <= is_write;
		end
		else if (leave_strobe || (state != dpram_host_pkg::S_STROBE))
		begin
			PORT_SELECT_N       <= 1'b1;
			FLAG_SPACE_SELECT_N <= 1'b1;
			PORT_WRITE_N        <= 1'b1;
			PORT_OUT_DRIVE_N    <= 1'b1;
		end
	end

	// Read data and flag result caught at strobe end
	always_ff @(posedge MCLK or negedge NRST)
	begin
		if (!NRST)
		begin
			rdata_reg <= '0;
			grant     <= 1'b0;
		end
		else if (leave_strobe)
		begin
			if (!is_write)
				rdata_reg <= PORT_DATA_I;
			if ((op == dpram_host_pkg::OP_FLAG_TAKE) && take_read)
				grant <= (PORT_DATA_I[dpram_host_pkg::FLAG_BIT] == dpram_host_pkg::FLAG_REQUEST);
			else if ((op == dpram_host_pkg::OP_FLAG_WR)
				&& (wdata_reg[dpram_host_pkg::FLAG_BIT] != dpram_host_pkg::FLAG_REQUEST))
				grant <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Events and interrupt
	// ------------------------------------------------------------
	// Pins are push-pull, so no pull-up guessing is needed
	always_ff @(posedge MCLK or negedge NRST)
	begin
		if (!NRST)
			int_prev <= 1'b1;
		else
			int_prev <= PORT_INT_N;
	end

	always_comb
	begin
		irq_set = '0;
		irq_set[dpram_host_pkg::IRQ_DONE]     = (state == dpram_host_pkg::S_RELEASE) && !more_phase;
		irq_set[dpram_host_pkg::IRQ_CONT]     = (state == dpram_host_pkg::S_STROBE)
			&& !PORT_CONTENTION_N;
		irq_set[dpram_host_pkg::IRQ_PORT_INT] = int_prev && !PORT_INT_N;
	end

	assign irq_clr = rd_take && addr_ok && (ofs == dpram_host_pkg::REG_IRQ_STAT);

	event_flags #(
		.W (dpram_host_pkg::IRQ_W)
	) u_flags (
		.clk   (MCLK),
		.rst_n (NRST),
		.set   (irq_set),
		.clr   (irq_clr),
		.mask  (irq_mask),
		.flags (irq_flags),
		.irq   (IRQ)
	);

endmodule

`default_nettype wire

// ---- src/dpram_host_pkg.sv ----
// Constants, register map and state types for the dual-port memory host controller.
// Assumes a 10 MHz clock and one port of the memory wired directly to the pins.

`default_nettype none

package dpram_host_pkg;

	// ------------------------------------------------------------
	// Widths of the memory port and of the event flags
	// ------------------------------------------------------------
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int IRQ_W  = 3;

	// ------------------------------------------------------------
	// Register byte offsets on the bus
	// ------------------------------------------------------------
	localparam logic [4:0] REG_CMD      = 5'h00;
	localparam logic [4:0] REG_ADDR     = 5'h04;
	localparam logic [4:0] REG_WDATA    = 5'h08;
	localparam logic [4:0] REG_RDATA    = 5'h0c;
	localparam logic [4:0] REG_STATUS   = 5'h10;
	localparam logic [4:0] REG_CFG      = 5'h14;
	localparam logic [4:0] REG_IRQ_STAT = 5'h18;
	localparam logic [4:0] REG_IRQ_MASK = 5'h1c;
	localparam int         REG_OFS_W    = 5;

	// ------------------------------------------------------------
	// Command codes, written to the low bits of the command register
	// ------------------------------------------------------------
	localparam int         OP_W        = 3;
	localparam logic [2:0] OP_MEM_RD   = 3'h0;
	localparam logic [2:0] OP_MEM_WR   = 3'h1;
	localparam logic [2:0] OP_FLAG_RD   = 3'h2;
	localparam logic [2:0] OP_FLAG_WR   = 3'h3;
	localparam logic [2:0] OP_FLAG_TAKE = 3'h4;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int ST_BUSY_BIT  = 0;
	localparam int ST_GRANT_BIT = 1;
	localparam int ST_CONT_BIT  = 2;
	localparam int ST_INT_BIT   = 3;
	localparam int CFG_ROLE_BIT = 0;
	localparam int IRQ_DONE     = 0;
	localparam int IRQ_CONT     = 1;
	localparam int IRQ_PORT_INT = 2;
	localparam int FLAG_BIT     = 0;

	// ------------------------------------------------------------
	// Reset values and fixed codes
	// ------------------------------------------------------------
	localparam logic       ROLE_RESET  = 1'b1;
	localparam logic       FLAG_REQUEST = 1'b0;
	localparam logic [1:0] HTRANS_NSEQ = 2'b10;
	localparam logic       HRESP_OKAY  = 1'b0;
	localparam logic [4:0] WORD_ZERO_HI = 5'h00;

	// ------------------------------------------------------------
	// Timing: strobe width rounded up to whole cycles
	// ------------------------------------------------------------
	localparam int         CLK_PERIOD_NS = 100;
	localparam int         T_ACCESS_NS   = 55;
	localparam logic [3:0] ACCESS_CYC    =
		4'((T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] CNT_LAST      = 4'h1;

	typedef enum logic [1:0] {S_IDLE, S_SETUP, S_STROBE, S_RELEASE} state_t;

endpackage

`default_nettype wire

// ---- src/event_flags.sv ----
// Sticky event flags with clear-on-read, mask and one level interrupt.
// Assumes set and clear pulses are synchronous to clk.

`timescale 1ns/1ps
`default_nettype none

module event_flags #(
	parameter int W = 3
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] set,
	input  wire logic         clr,
	input  wire logic [W-1:0] mask,
	output var  logic [W-1:0] flags,
	output var  logic         irq
);

	// ------------------------------------------------------------
	// Flags: a set in the clearing cycle survives
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			flags <= '0;
		else if (clr)
			flags <= set;
		else
			flags <= flags | set;
	end

	// Level interrupt while any unmasked flag stands
	always_comb
	begin
		irq = |(flags & mask);
	end

endmodule

`default_nettype wire

// ---- tb/dpram_host_monitor.sv ----
// Checker for the memory-port pins of the host controller.
// Assumes a bind into dpram_host and sight of its ports only.
`timescale 1ns/1ps
`default_nettype none
module dpram_host_monitor (
	input wire logic        MCLK,
	input wire logic        NRST,
	input wire logic [14:0] PORT_ADDR,
	input wire logic [7:0]  PORT_DATA_O,
	input wire logic [7:0]  PORT_DATA_OE,
	input wire logic        PORT_SELECT_N,
	input wire logic        FLAG_SPACE_SELECT_N,
	input wire logic        PORT_WRITE_N,
	input wire logic        PORT_OUT_DRIVE_N,
	input wire logic        PORT_CONTENTION_N
);
	// ------------------------------------------------------------
	// One clock domain, quiet during reset
	// ------------------------------------------------------------
	default clocking @(posedge MCLK);
	endclocking
	default disable iff (!NRST);
	// Strobe edges with no contention pending
	sequence strobe_go;
		$fell(PORT_WRITE_N) && PORT_CONTENTION_N;
	endsequence
	sequence fetch_go;
		$fell(PORT_OUT_DRIVE_N) && PORT_CONTENTION_N;
	endsequence
	// ------------------------------------------------------------
	// Pin relations
	// ------------------------------------------------------------
	chk_sel_excl: assert property (PORT_SELECT_N || FLAG_SPACE_SELECT_N)
		else $error("both selects low");
	chk_strobe_sel: assert property ((!PORT_WRITE_N || !PORT_OUT_DRIVE_N) |->
		(PORT_SELECT_N != FLAG_SPACE_SELECT_N)) else $error("strobe without select");
	chk_wr_drive: assert property (!PORT_WRITE_N |-> PORT_DATA_OE == 8'hff)
		else $error("write without data drive");
	chk_rd_float: assert property (!PORT_OUT_DRIVE_N |-> PORT_WRITE_N && PORT_DATA_OE == 8'h00)
		else $error("read while driving");
	chk_oe_release: assert property ($rose(PORT_WRITE_N) |=> PORT_DATA_OE == 8'h00)
		else $error("data lines not released");
	chk_strobe_one: assert property (strobe_go |=> PORT_WRITE_N)
		else $error("write strobe width");
	chk_fetch_one: assert property (fetch_go |=> PORT_OUT_DRIVE_N)
		else $error("read strobe width");
	chk_cont_hold: assert property ((!PORT_WRITE_N && !PORT_CONTENTION_N) |=> !PORT_WRITE_N)
		else $error("strobe ended under contention");
	chk_hold_steady: assert property ((!$past(PORT_WRITE_N) && !PORT_WRITE_N) |->
		$stable(PORT_ADDR) && $stable(PORT_DATA_O)) else $error("address moved in strobe");
	chk_flag_bit: assert property ((!FLAG_SPACE_SELECT_N && !PORT_WRITE_N) |->
		PORT_DATA_O[7:1] == 7'h00) else $error("flag write upper bits set");
endmodule
bind dpram_host dpram_host_monitor u_mon (.MCLK(MCLK), .NRST(NRST), .PORT_ADDR(PORT_ADDR),
	.PORT_DATA_O(PORT_DATA_O), .PORT_DATA_OE(PORT_DATA_OE), .PORT_SELECT_N(PORT_SELECT_N),
	.FLAG_SPACE_SELECT_N(FLAG_SPACE_SELECT_N), .PORT_WRITE_N(PORT_WRITE_N),
	.PORT_OUT_DRIVE_N(PORT_OUT_DRIVE_N), .PORT_CONTENTION_N(PORT_CONTENTION_N));
`default_nettype wire

// ---- tb/dpram_device_model.sv ----
// Behavioural model of the dual-port memory seen from one port.
// Assumes pins registered on the host clock; sampled mid-cycle.
`timescale 1ns/1ps
`default_nettype none
module dpram_device_model (
	input  wire logic        clk,
	input  wire logic [14:0] addr,
	input  wire logic [7:0]  dq,
	input  wire logic        sel_n,
	input  wire logic        flag_n,
	input  wire logic        wr_n,
	input  wire logic        oe_n,
	input  wire logic [7:0]  other_owns,
	input  wire logic        cont_req,
	input  wire logic        int_req,
	output var  logic [7:0]  dq_out,
	output var  logic        cont_n,
	output var  logic        int_n
);
	logic [7:0] mem [0:32767];
	logic [7:0] flag;
	logic [7:0] last;
	logic [7:0] rd_val;
	logic       drive;
	// Flags free at power-up
	initial
	begin
		flag = 8'hff;
		last = 8'h00;
	end
	// Read path; released lines show the inverse of the last value
	assign rd_val = !sel_n ? mem[addr] : {8{flag[addr[2:0]]}};
	assign drive  = wr_n && !oe_n && (sel_n != flag_n);
	assign dq_out = drive ? rd_val : ~last;
	// Mid-cycle writes; contention blocks a write, a held flag refuses a zero
	always @(negedge clk)
	begin
		if (drive)
			last <= rd_val;
		if (!sel_n && flag_n && !wr_n && !cont_req)
			mem[addr] <= dq;
		if (sel_n && !flag_n && !wr_n && (dq[0] || !other_owns[addr[2:0]]))
			flag[addr[2:0]] <= dq[0];
	end
	// Push-pull flags, never floating
	assign cont_n = !cont_req;
	assign int_n  = !int_req;
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the dual-port memory host controller.
// Assumes the device model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        mclk, nrst, hsel, hwrite, hreadyout, hresp, irq, role;
	logic        sel_n, flag_n, wr_n, oe_n, cont_n, int_n, cont_req, int_req;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, rd, ist;
	logic [14:0] paddr, a;
	logic [14:0] addrs [8];
	logic [7:0]  pdo, poe, pd, dev_q, other_owns, d;
	logic [7:0]  shadow [logic [14:0]];
	int          error_cnt, checks;
	// Far side and the shared data wire
	dpram_device_model u_dev (.clk(mclk), .addr(paddr), .dq(pd), .sel_n(sel_n), .flag_n(flag_n),
		.wr_n(wr_n), .oe_n(oe_n), .other_owns(other_owns), .cont_req(cont_req),
		.int_req(int_req), .dq_out(dev_q), .cont_n(cont_n), .int_n(int_n));
	assign pd = (poe != 8'h00) ? pdo : dev_q;
	dpram_host u_dut (.MCLK(mclk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
		.HREADYOUT(hreadyout), .HRESP(hresp), .HRDATA(hrdata), .IRQ(irq), .PORT_ADDR(paddr),
		.PORT_DATA_I(pd), .PORT_DATA_O(pdo), .PORT_DATA_OE(poe), .PORT_SELECT_N(sel_n),
		.FLAG_SPACE_SELECT_N(flag_n), .PORT_WRITE_N(wr_n), .PORT_OUT_DRIVE_N(oe_n),
		.PORT_CONTENTION_N(cont_n), .PORT_INT_N(int_n), .CASCADE_ROLE(role));
	// 10 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic results();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Bounded wait on the bus ready; a hang ends the run
	task automatic wait_rdy();
		int n;
		n = 0;
		do
			@(posedge mclk);
		while (hreadyout !== 1'b1 && ++n < 100);
		if (n >= 100)
		begin
			error_cnt++;
			results();
		end
	endtask
	task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= ad;
		htrans <= 2'b10;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic wr(input logic [4:0] o, input logic [31:0] wd);
		bus(1'b1, {27'h0, o}, wd);
	endtask
	task automatic rdc(input logic [4:0] o, input logic [31:0] exp);
		bus(1'b0, {27'h0, o}, 32'h0);
		check(rd, exp);
	endtask
	task automatic start(input logic [2:0] c, input logic [14:0] ad, input logic [7:0] wd);
		wr(dpram_host_pkg::REG_ADDR, {17'h0, ad});
		wr(dpram_host_pkg::REG_WDATA, {24'h0, wd});
		wr(dpram_host_pkg::REG_CMD, {29'h0, c});
	endtask
	// Poll busy, then collect and clear the events
	task automatic finish();
		int n;
		n = 0;
		do
			bus(1'b0, {27'h0, dpram_host_pkg::REG_STATUS}, 32'h0);
		while (rd[dpram_host_pkg::ST_BUSY_BIT] !== 1'b0 && ++n < 50);
		if (n >= 50)
		begin
			error_cnt++;
			results();
		end
		bus(1'b0, {27'h0, dpram_host_pkg::REG_IRQ_STAT}, 32'h0);
		ist = rd;
		check(ist[dpram_host_pkg::IRQ_DONE], 1'b1);
	endtask
	task automatic op(input logic [2:0] c, input logic [14:0] ad, input logic [7:0] wd);
		start(c, ad, wd);
		finish();
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		{nrst, hsel, hwrite, htrans, haddr, hwdata, cont_req, int_req, other_owns} = '0;
		hsize = 3'h2;
		error_cnt = 0;
		checks = 0;
		void'($urandom(78));
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		check({role, sel_n, flag_n, wr_n, oe_n, poe}, 13'h1f00);
		rdc(dpram_host_pkg::REG_CFG, 32'h1);
		rdc(dpram_host_pkg::REG_IRQ_MASK, 32'h0);
		bus(1'b1, 32'h100, 32'hffff_ffff);
		bus(1'b0, 32'h100, 32'h0);
		check(rd, 32'h0);
		check({31'h0, hresp}, 32'h0);
		$display("test reset done");
		// Random words, corner addresses first
		for (int i = 0; i < 8; i++)
		begin
			a = (i == 0) ? 15'h0000 : (i == 1) ? 15'h7fff : 15'($urandom);
			d = 8'($urandom);
			shadow[a] = d;
			addrs[i] = a;
			op(dpram_host_pkg::OP_MEM_WR, a, d);
		end
		foreach (addrs[i])
		begin
			op(dpram_host_pkg::OP_MEM_RD, addrs[i], 8'h00);
			rdc(dpram_host_pkg::REG_RDATA, {24'h0, shadow[addrs[i]]});
		end
		$display("test memory done");
		// Each flag alone: write zero, neighbour stays free, then release
		for (int i = 0; i < 8; i++)
		begin
			a = {12'($urandom), 3'(i)};
			op(dpram_host_pkg::OP_FLAG_WR, a, 8'($urandom) & 8'hfe);
			op(dpram_host_pkg::OP_FLAG_RD, a, 8'h00);
			rdc(dpram_host_pkg::REG_RDATA, 32'h00);
			op(dpram_host_pkg::OP_FLAG_RD, a ^ 15'h1, 8'h00);
			rdc(dpram_host_pkg::REG_RDATA, 32'hff);
			op(dpram_host_pkg::OP_FLAG_WR, a, 8'h01);
		end
		// Take refused while the far port holds it, then granted and freed
		other_owns <= 8'h08;
		op(dpram_host_pkg::OP_FLAG_TAKE, 15'h0003, 8'h00);
		rdc(dpram_host_pkg::REG_STATUS, 32'h0);
		other_owns <= 8'h00;
		op(dpram_host_pkg::OP_FLAG_TAKE, 15'h0003, 8'h00);
		rdc(dpram_host_pkg::REG_STATUS, 32'h2);
		op(dpram_host_pkg::OP_FLAG_WR, 15'h0003, 8'h01);
		rdc(dpram_host_pkg::REG_STATUS, 32'h0);
		$display("test flags done");
		// Write held off by contention, lands after release
		cont_req <= 1'b1;
		start(dpram_host_pkg::OP_MEM_WR, 15'h0123, 8'h5a);
		repeat (6) @(posedge mclk);
		rdc(dpram_host_pkg::REG_STATUS, 32'h5);
		cont_req <= 1'b0;
		finish();
		check(ist[dpram_host_pkg::IRQ_CONT], 1'b1);
		op(dpram_host_pkg::OP_MEM_RD, 15'h0123, 8'h00);
		rdc(dpram_host_pkg::REG_RDATA, 32'h5a);
		$display("test contention done");
		// Port interrupt: unmasked raises the line, read clears, masked stays low
		wr(dpram_host_pkg::REG_IRQ_MASK, 32'h4);
		int_req <= 1'b1;
		repeat (4) @(posedge mclk);
		check(irq, 1'b1);
		rdc(dpram_host_pkg::REG_STATUS, 32'h8);
		rdc(dpram_host_pkg::REG_IRQ_STAT, 32'h4);
		@(posedge mclk);
		check(irq, 1'b0);
		int_req <= 1'b0;
		wr(dpram_host_pkg::REG_IRQ_MASK, 32'h0);
		int_req <= 1'b1;
		repeat (4) @(posedge mclk);
		check(irq, 1'b0);
		rdc(dpram_host_pkg::REG_IRQ_STAT, 32'h4);
		int_req <= 1'b0;
		$display("test interrupt done");
		// Cascade role follows the configuration bit
		wr(dpram_host_pkg::REG_CFG, 32'h0);
		@(posedge mclk);
		check(role, 1'b0);
		wr(dpram_host_pkg::REG_CFG, 32'h1);
		@(posedge mclk);
		check(role, 1'b1);
		$display("test role done");
		results();
	end
endmodule
`default_nettype wire
